// ==== reqwin_map.vh ====
// Register map, field positions and timing constants for the request front end
`ifndef REQWIN_MAP_VH
`define REQWIN_MAP_VH

// Word offsets in bytes
`define OFS_CTRL          4'h0
`define OFS_DELAY         4'h4
`define OFS_PHASE         4'h8
`define OFS_STATUS        4'hc

// Control register fields
`define CTRL_FORCE        0
`define CTRL_BIAS_LO      1
`define CTRL_FUNC_LO      3
`define CTRL_CAPEN        5
`define CTRL_PMODE_LO     6
`define CTRL_PATH_LO      8
`define CTRL_RESET        32'h0000_0000

// Delay register fields
`define DLY_CNT_LO        0
`define DLY_STEP_LO       4
`define DLY_DIV_LO        6
`define DELAY_RESET       32'h0000_0000

// Phase register fields
`define PH_SEL_LO         0
`define PH_Q_LO           2
`define PH_I_LO           9
`define PHASE_RESET       32'h0000_0000

// Status register fields
`define ST_POS_LO         0
`define ST_VALID          4
`define ST_SYNCED         5
`define ST_STEP_LO        16

// Function modes
`define FUNC_REQUEST      2'h0
`define FUNC_SYNC         2'h1
`define FUNC_WINDOW       2'h2

// Pulse modes and delay path codes
`define PMODE_CONT        2'h0
`define PMODE_PULSER      2'h1
`define PMODE_REPEATER    2'h2
`define PATH_ALL_MODES    2'h2

// Timing
`define CLK_PERIOD_PS     50000
`define HOLD_CLK_PERIODS  3
`define HOLD_EXTRA_PS     1600
`define HOLD_CYCLES       (`HOLD_CLK_PERIODS + \
  (`HOLD_EXTRA_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== req_pin_sync.v ====
// Three-stage synchroniser with agreement filter for the request pin
`timescale 1ns/1ps
`default_nettype none
module req_pin_sync (
  input  wire i_ref_clk,  // Input clock
  input  wire i_rst,      // Async reset, active high
  input  wire i_pin,      // Raw asynchronous level
  output reg  o_level     // Filtered synchronous level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== req_delay_line.v ====
// Programmable clock-cycle delay line for the internal request level
`timescale 1ns/1ps
`default_nettype none
module req_delay_line (
  input  wire       i_ref_clk,  // Input clock
  input  wire       i_rst,      // Async reset, active high
  input  wire       i_din,      // Level to delay
  input  wire [3:0] i_delay,    // Added delay in cycles, on top of the one output register cycle
  output reg        o_dout      // Delayed level
);
  reg [15:0] tap_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tap_q  <= 16'h0000;
      o_dout <= 1'b0;
    end else begin
      tap_q  <= {tap_q[14:0], i_din};
      o_dout <= (i_delay == 4'h0) ? i_din : tap_q[i_delay - 4'h1];
    end
  end
endmodule
`default_nettype wire

// ==== reqwin_front.v ====
// Request input front end: force, bias, delay, windowing and divider sync
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`include "reqwin_map.vh"
`timescale 1ns/1ps
`default_nettype none
module reqwin_front (
  input  wire        i_ref_clk,          // Input clock, 20 MHz
  input  wire        i_rst,              // Async reset, active high
  input  wire [3:0]  i_avs_address,      // Byte address
  input  wire        i_avs_read,         // Read strobe
  input  wire        i_avs_write,        // Write strobe
  input  wire [31:0] i_avs_writedata,    // Write data
  input  wire [3:0]  i_avs_byteenable,   // Byte lanes
  output reg  [31:0] o_avs_readdata,     // Read data
  output reg         o_avs_waitrequest,  // Stall
  input  wire        i_ref_request_input,// Request pin level
  output reg  [1:0]  o_request_bias_select, // Common mode select
  output reg  [1:0]  o_request_step_size,   // Delay step code
  output reg         o_ref_request,      // Delayed request level
  output reg         o_div_sync,         // Divider align pulse
  output reg  [1:0]  o_ref_pulse_mode,   // Generator or repeater
  output reg         o_retime_ready,     // Repeater retime configured
  output reg  [8:0]  o_delay_step_number,// Interpolator step count
  output reg  [3:0]  o_interp_phase      // Interpolator divider phase
);
  reg  [31:0] ctrl_q;
  reg  [31:0] delay_q;
  reg  [31:0] phase_q;
  reg  [3:0]  pos_q;
  reg         pos_valid_q;
  reg         synced_q;
  reg  [3:0]  icnt_q;
  reg  [3:0]  hold_q;
  reg         req_prev_q;
  reg         ack_q;
  reg  [31:0] rd_d;
  wire        pin_lvl;
  wire        dly_out;
  wire        req_lvl;
  wire        req_rise;
  wire        pin_rise;
  wire [1:0]  func_mode;
  wire [1:0]  div_code;
  wire [3:0]  div_last;
  wire        access;

  // Merge byte lanes into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = wdat[k*8 +: 8];
        end
      end
    end
  endfunction

  // Interpolator step count from phase and weights
  function [8:0] step_num;
    input [1:0] ph;
    input [6:0] q;
    input [6:0] iw;
    begin
      case (ph)
        2'h3:    step_num = 9'h07f - {2'h0, iw};
        2'h2:    step_num = 9'h0fe - {2'h0, q};
        2'h0:    step_num = 9'h17d - {2'h0, iw};
        default: step_num = 9'h1fc - {2'h0, q};
      endcase
    end
  endfunction

  assign func_mode = ctrl_q[`CTRL_FUNC_LO +: 2];
  assign div_code  = delay_q[`DLY_DIV_LO +: 2];
  // Divide by 2, 4, 8, 16
  assign div_last  = (4'h2 << div_code) - 4'h1;
  assign access    = (i_avs_read | i_avs_write) & o_avs_waitrequest & ~ack_q;

  req_pin_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     (i_ref_request_input),
    .o_level   (pin_lvl)
  );

  assign req_lvl = pin_lvl | ctrl_q[`CTRL_FORCE];

  req_delay_line u_dly (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_din     (req_lvl),
    .i_delay   (delay_q[`DLY_CNT_LO +: 4]),
    .o_dout    (dly_out)
  );

  reg pin_prev_q;
  assign req_rise = req_lvl & ~req_prev_q;
  assign pin_rise = pin_lvl & ~pin_prev_q;

  // Bus slave: one wait cycle, then answer
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      ack_q             <= 1'b0;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      ack_q             <= access;
      o_avs_waitrequest <= ~access;
      if (access && i_avs_read) begin
        o_avs_readdata <= rd_d;
      end
    end
  end

  always @* begin
    rd_d = 32'h0000_0000;
    case (i_avs_address)
      `OFS_CTRL:  rd_d = ctrl_q;
      `OFS_DELAY: rd_d = delay_q;
      `OFS_PHASE: rd_d = phase_q;
      `OFS_STATUS: begin
        rd_d[`ST_POS_LO +: 4]  = pos_q;
        rd_d[`ST_VALID]        = pos_valid_q;
        rd_d[`ST_SYNCED]       = synced_q;
        rd_d[`ST_STEP_LO +: 9] = o_delay_step_number;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Config writes; none of these starts a divider sync
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q  <= `CTRL_RESET;
      delay_q <= `DELAY_RESET;
      phase_q <= `PHASE_RESET;
    end else if (access && i_avs_write) begin
      case (i_avs_address)
        `OFS_CTRL: begin
          ctrl_q <= merge(ctrl_q, i_avs_writedata, i_avs_byteenable)
                    & 32'h0000_03ff;
        end
        `OFS_DELAY: begin
          delay_q <= merge(delay_q, i_avs_writedata, i_avs_byteenable)
                     & 32'h0000_00ff;
        end
        `OFS_PHASE: begin
          phase_q <= merge(phase_q, i_avs_writedata, i_avs_byteenable)
                     & 32'h0000_ffff;
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // Interpolator phase counter and divider alignment
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      icnt_q     <= 4'h0;
      o_div_sync <= 1'b0;
      synced_q   <= 1'b0;
      req_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      req_prev_q <= req_lvl;
      pin_prev_q <= pin_lvl;
      if (func_mode == `FUNC_SYNC && pin_rise) begin
        o_div_sync <= 1'b1;
        icnt_q     <= 4'h0;
        synced_q   <= 1'b1;
      end else begin
        o_div_sync <= 1'b0;
        icnt_q     <= (icnt_q >= div_last) ? 4'h0 : icnt_q + 4'h1;
      end
    end
  end

  // Windowing capture from the pin path
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q       <= 4'h0;
      pos_valid_q <= 1'b0;
      hold_q      <= 4'h0;
    end else if (func_mode == `FUNC_WINDOW && ctrl_q[`CTRL_CAPEN]) begin
      if (pin_rise) begin
        pos_q       <= icnt_q;
        pos_valid_q <= 1'b0;
        hold_q      <= 4'h1;
      end else if (!pin_lvl) begin
        hold_q <= 4'h0;
      end else if (hold_q != 4'h0 && hold_q < `HOLD_CYCLES) begin
        hold_q <= hold_q + 4'h1;
      end else if (hold_q == `HOLD_CYCLES) begin
        pos_valid_q <= 1'b1;
      end
    end else begin
      hold_q <= 4'h0;
    end
  end

  // Output drivers
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_request_bias_select <= 2'h0;
      o_request_step_size   <= 2'h0;
      o_ref_request         <= 1'b0;
      o_ref_pulse_mode      <= 2'h0;
      o_retime_ready        <= 1'b0;
      o_delay_step_number   <= 9'h000;
      o_interp_phase        <= 4'h0;
    end else begin
      o_request_bias_select <= ctrl_q[`CTRL_BIAS_LO +: 2];
      o_request_step_size   <= delay_q[`DLY_STEP_LO +: 2];
      o_ref_request <= (func_mode == `FUNC_REQUEST) ? dly_out : 1'b0;
      o_ref_pulse_mode <= ctrl_q[`CTRL_PMODE_LO +: 2];
      o_retime_ready <= (ctrl_q[`CTRL_PMODE_LO +: 2] == `PMODE_REPEATER) &&
                        (ctrl_q[`CTRL_PATH_LO +: 2] == `PATH_ALL_MODES);
      o_delay_step_number <= step_num(phase_q[`PH_SEL_LO +: 2],
                                      phase_q[`PH_Q_LO +: 7],
                                      phase_q[`PH_I_LO +: 7]);
      o_interp_phase <= icnt_q;
    end
  end

  // Request edge seen, for future pulse use
  wire unused_rise = req_rise;
endmodule
`default_nettype wire

// ==== reqwin_front_chk.sv ====
// Port checker for the request front end
`timescale 1ns/1ps
`default_nettype none
module reqwin_front_chk (
  input wire logic       i_ref_clk,           // Clock
  input wire logic       i_rst,               // Reset
  input wire logic       i_avs_read,          // Read
  input wire logic       i_avs_write,         // Write
  input wire logic       i_ref_request_input, // Pin
  input wire logic       o_avs_waitrequest,   // Stall
  input wire logic       o_div_sync,          // Align pulse
  input wire logic [1:0] o_ref_pulse_mode,    // Pulse mode
  input wire logic       o_retime_ready,      // Retime ok
  input wire logic [8:0] o_delay_step_number, // Steps
  input wire logic [3:0] o_interp_phase       // Phase
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("stall low too long");
  property p_wait_ans;
    $rose(i_avs_read || i_avs_write) |-> ##[1:3] !o_avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_retime; o_retime_ready |-> o_ref_pulse_mode == 2'h2; endproperty
  a_retime: assert property (p_retime) else $error("retime bad mode");
  property p_sync_one; o_div_sync |=> !o_div_sync; endproperty
  a_sync_one: assert property (p_sync_one) else $error("long sync");
  property p_sync_pin; o_div_sync |-> $past(i_ref_request_input, 2); endproperty
  a_sync_pin: assert property (p_sync_pin) else $error("sync no pin");
  property p_sync_phase; o_div_sync |-> ##[0:1] o_interp_phase == 4'h0; endproperty
  a_sync_phase: assert property (p_sync_phase) else $error("phase");
  property p_sync_filt; $rose(i_ref_request_input) |-> !o_div_sync [*2]; endproperty
  a_sync_filt: assert property (p_sync_filt) else $error("early sync");
  property p_step_max; o_delay_step_number <= 9'd508; endproperty
  a_step_max: assert property (p_step_max) else $error("step range");
endmodule
bind reqwin_front reqwin_front_chk reqwin_front_chk_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_ref_request_input(i_ref_request_input),
  .o_avs_waitrequest(o_avs_waitrequest), .o_div_sync(o_div_sync),
  .o_ref_pulse_mode(o_ref_pulse_mode), .o_retime_ready(o_retime_ready),
  .o_delay_step_number(o_delay_step_number),
  .o_interp_phase(o_interp_phase));
`default_nettype wire

// ==== req_source.sv ====
// Upstream request pulse source
`timescale 1ns/1ps
`default_nettype none
module req_source (
  input  wire logic i_ref_clk, // Clock
  output var logic  o_req      // Request level
);
  initial o_req = 1'b0;
  task automatic pulse(input int hi, input int gap);
    @(posedge i_ref_clk);
    o_req <= 1'b1;
    repeat (hi) @(posedge i_ref_clk);
    o_req <= 1'b0;
    repeat (gap) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== reqwin_front_bench.sv ====
// Self-checking bench for the request front end
`timescale 1ns/1ps
`default_nettype none
module reqwin_front_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q, c;
  logic        wreq, pin, refq, dsync, rtr;
  logic [1:0]  bias, step, pmode;
  logic [8:0]  stepn;
  logic [3:0]  iph;
  int          failures = 0;
  int          check_count = 0;
  int          nsync, n0, n1, qw, iw;
  always #25 clk = ~clk;
  always @(posedge clk) if (dsync === 1'b1) nsync <= nsync + 1;
  reqwin_front reqwin_front_i (.i_ref_clk(clk), .i_rst(rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_ref_request_input(pin), .o_request_bias_select(bias),
    .o_request_step_size(step), .o_ref_request(refq), .o_div_sync(dsync),
    .o_ref_pulse_mode(pmode), .o_retime_ready(rtr),
    .o_delay_step_number(stepn), .o_interp_phase(iph));
  req_source req_source_i (.i_ref_clk(clk), .o_req(pin));
  function automatic int step_model(int ph, int qv, int iv);
    int base[4] = '{381, 508, 254, 127};
    return base[ph] - ((ph == 1 || ph == 2) ? qv : iv);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 40);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) failures++;
  endtask
  task automatic lat(output int n);
    fork
      req_source_i.pulse(10, 80);
      begin
        n = 0;
        do begin @(posedge clk); n++; end while (refq !== 1'b1 && n < 60);
      end
    join
  endtask
  task report_and_stop;
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    report_and_stop;
  end
  initial begin
    q = $urandom(67141);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 12; a += 4) begin
      bus(0, a[3:0], 0);
      chk("reset reg", q, 0);
    end
    for (int b = 0; b < 4; b++) begin
      c = (2 << 8) | ((b % 3) << 6) | (b << 1);
      bus(1, 4'h0, c);
      bus(0, 4'h0, 0);
      chk("ctrl", q, c);
      chk("bias", bias, b);
      chk("pmode", pmode, b % 3);
      chk("retime", rtr, (b % 3) == 2);
    end
    bus(0, 4'h1, 0);
    chk("unmapped", q, 0);
    // all four phases are swept with weights picked at random, before the windowing check
    for (int ph = 0; ph < 4; ph++) begin
      qw = $urandom % 128;
      iw = $urandom % 128;
      bus(1, 4'h8, (iw << 9) | (qw << 2) | ph);
      bus(0, 4'hc, 0);
      chk("step number", stepn, step_model(ph, qw, iw));
      chk("status step", q[24:16], step_model(ph, qw, iw));
    end
    c = $urandom % 4;
    bus(1, 4'h4, c << 4);
    repeat (2) @(posedge clk);
    chk("step size", step, c);
    bus(1, 4'h4, 0);
    lat(n0);
    bus(1, 4'h4, 5);
    lat(n1);
    chk("req delay", n1 - n0, 5);
    bus(1, 4'h0, 1);
    repeat (12) @(posedge clk);
    chk("force", refq, 1);
    bus(1, 4'h0, 0);
    bus(1, 4'h0, 32'h08);
    nsync = 0;
    req_source_i.pulse(10, 80);
    chk("sync count", nsync, 1);
    bus(0, 4'hc, 0);
    chk("synced", q[5], 1);
    nsync = 0;
    bus(1, 4'h0, 32'h09);
    repeat (20) @(posedge clk);
    chk("force sync", nsync, 0);
    bus(1, 4'h0, 0);
    bus(1, 4'h0, 32'h30);
    req_source_i.pulse(5, 80);
    bus(0, 4'hc, 0);
    chk("pos valid", q[4], 1);
    report_and_stop;
  end
endmodule
`default_nettype wire
